// [pkg/adcm_pkg.sv]
// constants and carrier types for the isolated adc bit stream master
package adcm_pkg;

    // =====================================================================
    // clocking
    localparam int unsigned MCLK_HZ = 16384000;
    localparam int unsigned FRAME_DIV = 16;
    localparam int unsigned SLAVE_DIV = 4;
    localparam int unsigned FRAME_HZ = MCLK_HZ / FRAME_DIV;
    localparam int unsigned SLAVE_HZ = MCLK_HZ / SLAVE_DIV;
    localparam logic [3:0] CNT_LAST = 4'hF;
    localparam logic [3:0] FRAME_RISE_CNT = 4'h1;
    localparam logic [3:0] FRAME_FALL_CNT = 4'h5;
    localparam logic [1:0] SLAVE_FALL_PH = 2'h2;
    localparam logic [1:0] SLAVE_RISE_PH = 2'h0;
    // slave rise at count 8 plus one cycle of synchroniser latency
    localparam logic [3:0] SLOT0_SAMPLE_CNT = 4'h9;
    localparam logic [1:0] SLOT_LAST = 2'h3;
    localparam logic [1:0] SLOT_TEMP = 2'h2;

    // =====================================================================
    // channels, slave reset, temperature framing
    localparam int unsigned NUM_CH = 4;
    localparam logic [3:0] RESET_PULSES = 4'h8;
    localparam int unsigned TEMP_FRAME_LEN = 16;
    localparam logic [4:0] TEMP_LEAD_ZEROS = 5'h00;
    localparam int unsigned TEMP_LEAD_MSB = 15;
    localparam int unsigned TEMP_LEAD_LSB = 11;
    localparam int unsigned TEMP_MARK0 = 10;
    localparam int unsigned TEMP_MARK1 = 5;
    localparam int unsigned TEMP_MARK2 = 0;
    localparam int unsigned TEMP_HI_MSB = 9;
    localparam int unsigned TEMP_HI_LSB = 6;
    localparam int unsigned TEMP_LO_MSB = 4;
    localparam int unsigned TEMP_LO_LSB = 1;

    // =====================================================================
    // filter
    localparam int unsigned SAMPLE_W = 10;
    localparam int unsigned AVG_FRAC = 8;
    localparam int unsigned HP_SHIFT = 4;

    typedef enum logic [1:0] {
        ADCM_RST_WAIT,
        ADCM_RST_PULSE,
        ADCM_RUN
    } adcm_rst_e;

    typedef struct packed {
        logic [NUM_CH-1:0] phase_v;
        logic [NUM_CH-1:0] aux_v;
        logic [NUM_CH-1:0] temp;
        logic [NUM_CH-1:0] current;
    } adcm_bits_s;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] phase_v;
        logic signed [SAMPLE_W-1:0] aux_v;
        logic signed [SAMPLE_W-1:0] current;
    } adcm_sample_s;

endpackage

// [src/adcm_master.sv]
// bit stream master: clock generation, slot demux, temperature offset, filters
`timescale 1ns/10ps
module adcm_master #(
    parameter int unsigned DEC = 64
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [adcm_pkg::NUM_CH-1:0] data_in,
    input wire logic [adcm_pkg::NUM_CH-1:0] aux_sel,
    output logic frame_clk,
    output logic slave_clock_output,
    output logic slave_reset_n,
    output logic [adcm_pkg::NUM_CH-1:0] channel_select_strobe,
    output adcm_pkg::adcm_bits_s frame_bits,
    output logic frame_bits_valid,
    output logic [adcm_pkg::NUM_CH-1:0][7:0] temp_offset,
    output logic [adcm_pkg::NUM_CH-1:0] temp_valid,
    output adcm_pkg::adcm_sample_s [adcm_pkg::NUM_CH-1:0] samples,
    output logic samples_valid
);

    localparam int unsigned DW = $clog2(DEC + 1);

    // =====================================================================
    // master clock divider
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic frame_q;
    logic sclk_q;

    // ref_clk is the master clock; all divides are exact so tolerance carries through
    assign cnt_d = (cnt_q == adcm_pkg::CNT_LAST) ? '0 : cnt_q + 4'h1;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // outputs registered from the next count so pins change on the count edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frame_q <= 1'b0;
            sclk_q <= 1'b1;
        end else begin
            frame_q <= (cnt_d >= adcm_pkg::FRAME_RISE_CNT) && (cnt_d < adcm_pkg::FRAME_FALL_CNT);
            sclk_q <= ~cnt_d[1];
        end
    end

    assign frame_clk = frame_q;
    assign slave_clock_output = sclk_q;

    // =====================================================================
    // input synchronisers and slot demux
    logic [adcm_pkg::NUM_CH-1:0] din_s1_q;
    logic [adcm_pkg::NUM_CH-1:0] din_s2_q;
    logic [3:0] rel_cnt;
    logic slot_hit;
    logic [1:0] slot_idx;
    adcm_pkg::adcm_bits_s acc_q;
    adcm_pkg::adcm_bits_s bits_q;
    logic bits_valid_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            din_s1_q <= '1;
            din_s2_q <= '1;
        end else begin
            din_s1_q <= data_in;
            din_s2_q <= din_s1_q;
        end
    end

    assign rel_cnt = cnt_q - adcm_pkg::SLOT0_SAMPLE_CNT;
    assign slot_hit = (rel_cnt[1:0] == 2'h0);
    assign slot_idx = rel_cnt[3:2];

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            acc_q <= '0;
            bits_q <= '0;
            bits_valid_q <= 1'b0;
        end else begin
            bits_valid_q <= slot_hit && (slot_idx == adcm_pkg::SLOT_LAST);
            if (slot_hit) begin
                case (slot_idx)
                    2'h0: acc_q.phase_v <= din_s2_q;
                    2'h1: acc_q.aux_v <= din_s2_q;
                    2'h2: acc_q.temp <= din_s2_q;
                    default: begin
                        bits_q <= '{phase_v: acc_q.phase_v, aux_v: acc_q.aux_v, temp: acc_q.temp,
                                    current: din_s2_q};
                    end
                endcase
            end
        end
    end

    assign frame_bits = bits_q;
    assign frame_bits_valid = bits_valid_q;

    // =====================================================================
    // temperature offset recovery and per-channel filters
    logic [DW-1:0] dec_q;
    logic dec_end;
    logic [adcm_pkg::NUM_CH-1:0] tmatch;
    logic samp_valid_q;

    assign dec_end = bits_valid_q && (dec_q == DW'(DEC - 1));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dec_q <= '0;
            samp_valid_q <= 1'b0;
        end else begin
            samp_valid_q <= dec_end;
            if (bits_valid_q) begin
                dec_q <= dec_end ? '0 : dec_q + DW'(1);
            end
        end
    end

    genvar gc;
    genvar gs;
    generate
        for (gc = 0; gc < adcm_pkg::NUM_CH; gc++) begin : g_ch
            logic [adcm_pkg::TEMP_FRAME_LEN-1:0] tsh_q;
            logic [adcm_pkg::TEMP_FRAME_LEN-1:0] tsh_d;
            logic [7:0] toff_q;
            logic tval_q;
            logic [2:0] sbit;
            logic signed [adcm_pkg::SAMPLE_W-1:0] y_q [3];

            assign tsh_d = {tsh_q[adcm_pkg::TEMP_FRAME_LEN-2:0], bits_q.temp[gc]};
            // a stuck-high line never shows five leading zeros, so it never validates
            assign tmatch[gc] = (tsh_d[adcm_pkg::TEMP_LEAD_MSB:adcm_pkg::TEMP_LEAD_LSB] == adcm_pkg::TEMP_LEAD_ZEROS)
                && tsh_d[adcm_pkg::TEMP_MARK0] && tsh_d[adcm_pkg::TEMP_MARK1] && tsh_d[adcm_pkg::TEMP_MARK2];

            always_ff @(posedge ref_clk or posedge reset) begin
                if (reset) begin
                    // idle line is high, so reset history cannot fake a delimiter
                    tsh_q <= '1;
                    toff_q <= '0;
                    tval_q <= 1'b0;
                end else if (bits_valid_q) begin
                    tsh_q <= tsh_d;
                    if (tmatch[gc]) begin
                        toff_q <= {tsh_d[adcm_pkg::TEMP_HI_MSB:adcm_pkg::TEMP_HI_LSB],
                                   tsh_d[adcm_pkg::TEMP_LO_MSB:adcm_pkg::TEMP_LO_LSB]};
                        tval_q <= 1'b1;
                    end
                end
            end

            assign temp_offset[gc] = toff_q;
            assign temp_valid[gc] = tval_q;

            assign sbit = {bits_q.phase_v[gc], bits_q.aux_v[gc], bits_q.current[gc]};

            // sinc1 decimator then first-order dc blocker; cheap, not a precision filter
            for (gs = 0; gs < 3; gs++) begin : g_st
                logic [DW-1:0] ones_q;
                logic [DW:0] ones_t;
                logic signed [adcm_pkg::SAMPLE_W-1:0] x_t;
                logic signed [adcm_pkg::SAMPLE_W+adcm_pkg::AVG_FRAC-1:0] avg_q;
                logic signed [adcm_pkg::SAMPLE_W+adcm_pkg::AVG_FRAC-1:0] err_t;

                assign ones_t = {1'b0, ones_q} + (DW+1)'(sbit[gs]);
                // all ones gives positive full scale
                assign x_t = adcm_pkg::SAMPLE_W'($signed({ones_t, 1'b0}) - $signed((DW+2)'(DEC)));
                assign err_t = $signed({x_t, adcm_pkg::AVG_FRAC'(0)}) - avg_q;

                always_ff @(posedge ref_clk or posedge reset) begin
                    if (reset) begin
                        ones_q <= '0;
                        avg_q <= '0;
                        y_q[gs] <= '0;
                    end else if (bits_valid_q) begin
                        ones_q <= dec_end ? '0 : ones_t[DW-1:0];
                        if (dec_end) begin
                            avg_q <= avg_q + (err_t >>> adcm_pkg::HP_SHIFT);
                            y_q[gs] <= adcm_pkg::SAMPLE_W'(err_t >>> adcm_pkg::AVG_FRAC);
                        end
                    end
                end
            end

            assign samples[gc] = '{phase_v: y_q[2], aux_v: y_q[1], current: y_q[0]};
        end
    endgenerate

    assign samples_valid = samp_valid_q;

    // =====================================================================
    // slave reset sequence and select strobes
    adcm_pkg::adcm_rst_e rst_q;
    logic [3:0] pulses_q;
    logic srst_n_q;
    logic [adcm_pkg::NUM_CH-1:0] strobe_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rst_q <= adcm_pkg::ADCM_RST_WAIT;
            pulses_q <= '0;
        end else begin
            case (rst_q)
                adcm_pkg::ADCM_RST_WAIT: begin
                    if (cnt_q == adcm_pkg::CNT_LAST) begin
                        rst_q <= adcm_pkg::ADCM_RST_PULSE;
                    end
                end
                adcm_pkg::ADCM_RST_PULSE: begin
                    if (cnt_d[1:0] == adcm_pkg::SLAVE_FALL_PH) begin
                        pulses_q <= pulses_q + 4'h1;
                    end
                    if ((pulses_q == adcm_pkg::RESET_PULSES) && (cnt_d[1:0] == adcm_pkg::SLAVE_RISE_PH)) begin
                        rst_q <= adcm_pkg::ADCM_RUN;
                    end
                end
                adcm_pkg::ADCM_RUN: begin
                    rst_q <= adcm_pkg::ADCM_RUN;
                end
                default: begin
                    rst_q <= adcm_pkg::ADCM_RST_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            srst_n_q <= 1'b0;
            strobe_q <= '1;
        end else begin
            srst_n_q <= (rst_q == adcm_pkg::ADCM_RUN);
            case (rst_q)
                adcm_pkg::ADCM_RST_PULSE: begin
                    // after the eighth fall hold low until the release edge
                    strobe_q <= (pulses_q == adcm_pkg::RESET_PULSES) ? '0 : {adcm_pkg::NUM_CH{~cnt_d[1]}};
                end
                adcm_pkg::ADCM_RUN: begin
                    // strobes return high with the reset release, then follow the select level
                    strobe_q <= srst_n_q ? aux_sel : '1;
                end
                default: begin
                    strobe_q <= '1;
                end
            endcase
        end
    end

    assign slave_reset_n = srst_n_q;
    assign channel_select_strobe = strobe_q;

    // =====================================================================
    // checks
    logic [2:0] falls_q;
    logic frame_p_q;
    logic sclk_p_q;
    logic frame_seen_q;

    // previous pin levels kept here so the slot count does not lean on the divider count
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            falls_q <= '0;
            frame_p_q <= 1'b0;
            sclk_p_q <= 1'b1;
            frame_seen_q <= 1'b0;
        end else begin
            frame_p_q <= frame_q;
            sclk_p_q <= sclk_q;
            if (frame_p_q && !frame_q) begin
                falls_q <= '0;
                frame_seen_q <= 1'b1;
            end else if (sclk_p_q && !sclk_q) begin
                falls_q <= falls_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_frame_high_len: assert property ($rose(frame_clk) |-> frame_clk[*4] ##1 !frame_clk[*8])
        else $error("frame clock duty wrong");
    a_frame_period: assert property ($rose(frame_clk) |-> ##16 $rose(frame_clk))
        else $error("frame clock period not sixteen cycles");
    a_rise_lead: assert property ($rose(frame_clk) |-> ##1 $fell(slave_clock_output))
        else $error("frame rise not one cycle before slave fall");
    a_slave_div: assert property ($rose(slave_clock_output) |-> ##2 $fell(slave_clock_output) ##2
        $rose(slave_clock_output))
        else $error("slave clock not divide by four");
    a_four_slots: assert property ($fell(frame_clk) && frame_seen_q |-> $past(falls_q) == 3'h4)
        else $error("slot count per frame not four");
    a_bits_cadence: assert property (frame_bits_valid |-> ##16 frame_bits_valid)
        else $error("frame bits not every frame");
    a_temp_hold: assert property (!$past(tmatch[0] && bits_valid_q) |-> $stable(temp_offset[0]))
        else $error("temperature offset changed without match");
    a_temp_valid_cause: assert property ($rose(temp_valid[1]) |-> $past(tmatch[1] && bits_valid_q))
        else $error("temperature valid without delimiter");
    a_strobe_follow: assert property ((rst_q == adcm_pkg::ADCM_RUN) && slave_reset_n
        |=> channel_select_strobe == $past(aux_sel))
        else $error("strobe does not follow select");
    a_reset_release: assert property ($rose(slave_reset_n) |-> (channel_select_strobe == {adcm_pkg::NUM_CH{1'b1}})
        && ($past(pulses_q) == adcm_pkg::RESET_PULSES))
        else $error("slave reset released before eight pulses or strobes low");

    c_temp_found: cover property ($rose(temp_valid[0]));
    c_sample_out: cover property (samples_valid);
    c_reset_done: cover property ($rose(slave_reset_n));
    c_strobe_temp: cover property (slave_reset_n && $rose(channel_select_strobe[0]));

endmodule

// [verif/adcm_slave_model.sv]
// behavioural model of the four remote adc slaves on the bit stream link
`timescale 1ns/10ps
module adcm_slave_model (
    input wire logic frame_clk,
    input wire logic slave_clock_output,
    input wire logic [adcm_pkg::NUM_CH-1:0] present,
    input wire adcm_pkg::adcm_bits_s next_bits,
    input wire logic [adcm_pkg::NUM_CH-1:0][7:0] offset,
    output logic [adcm_pkg::NUM_CH-1:0] data_out,
    output adcm_pkg::adcm_bits_s last_frame
);
    // =====================================================================
    // frame state
    logic [2:0] slot;
    logic [3:0] tpos;
    logic [adcm_pkg::NUM_CH-1:0][15:0] word;
    adcm_pkg::adcm_bits_s cur;

    initial begin
        slot = 3'h4;
        tpos = 4'h0;
        data_out = '1;
        last_frame = '0;
    end

    // =====================================================================
    // a new frame starts at every frame clock fall, no idle frames
    always @(negedge frame_clk) begin
        // whole offset words only: latch a new value at word start
        if (tpos == 4'h0) begin
            for (int ch = 0; ch < adcm_pkg::NUM_CH; ch++) begin
                word[ch] = {5'h00, 1'b1, offset[ch][7:4], 1'b1, offset[ch][3:0], 1'b1};
            end
        end
        cur = next_bits;
        for (int ch = 0; ch < adcm_pkg::NUM_CH; ch++) begin
            cur.temp[ch] = word[ch][4'hF - tpos];
        end
        // an absent slave is a line tied high
        cur.phase_v = cur.phase_v | ~present;
        cur.aux_v = cur.aux_v | ~present;
        cur.temp = cur.temp | ~present;
        cur.current = cur.current | ~present;
        tpos = tpos + 4'h1;
        slot = 3'h0;
    end

    // =====================================================================
    // one bit per slave clock fall, fixed slot order
    always @(negedge slave_clock_output) begin
        if (slot < 3'h4) begin
            case (slot)
                3'h0: data_out <= cur.phase_v;
                3'h1: data_out <= cur.aux_v;
                3'h2: data_out <= cur.temp;
                default: begin
                    data_out <= cur.current;
                    last_frame <= cur;
                end
            endcase
            slot = slot + 3'h1;
        end
    end
endmodule

// [verif/test_isolated_adc_bitstream_master.sv]
// self-checking testbench for the bit stream master
`timescale 1ns/10ps
module test_isolated_adc_bitstream_master;
    // =====================================================================
    // signals
    localparam int DEC = 4;
    localparam int LIMIT = 24000;
    logic ref_clk = 1'b0;
    logic reset;
    logic [3:0] aux_sel;
    logic [3:0] data_in;
    logic [3:0] present;
    logic [3:0][7:0] offs;
    logic [7:0] hold;
    adcm_pkg::adcm_bits_s nb;
    adcm_pkg::adcm_bits_s exp_bits;
    logic frame_clk, slave_clock_output, slave_reset_n, frame_bits_valid, samples_valid;
    logic [3:0] channel_select_strobe, temp_valid;
    adcm_pkg::adcm_bits_s frame_bits;
    logic [3:0][7:0] temp_offset;
    adcm_pkg::adcm_sample_s [3:0] samples;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int fr_c = 0;
    int sf_c = 0;
    int sf_n = 0;
    int st_n = 0;
    int fv_n = 0;
    int fv_total = 0;
    int run_n = 0;
    bit mon_on = 0;
    bit rise_pend = 0;
    bit ff_seen = 0;
    bit sv_seen = 0;
    logic fc_p = 1'b0;
    logic sc_p = 1'b1;
    logic sr_p = 1'b0;
    logic [3:0] st_p = 4'hF;

    always #2 ref_clk = ~ref_clk;

    adcm_master #(.DEC(DEC)) dut_u (.ref_clk(ref_clk), .reset(reset), .data_in(data_in), .aux_sel(aux_sel),
        .frame_clk(frame_clk), .slave_clock_output(slave_clock_output), .slave_reset_n(slave_reset_n),
        .channel_select_strobe(channel_select_strobe), .frame_bits(frame_bits),
        .frame_bits_valid(frame_bits_valid), .temp_offset(temp_offset), .temp_valid(temp_valid),
        .samples(samples), .samples_valid(samples_valid));

    adcm_slave_model slave_u (.frame_clk(frame_clk), .slave_clock_output(slave_clock_output),
        .present(present), .next_bits(nb), .offset(offs), .data_out(data_in), .last_frame(exp_bits));

    // =====================================================================
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_frames(input int n);
        repeat (n) @(posedge frame_bits_valid);
        @(negedge ref_clk);
    endtask

    // a hang ends the run as a mismatch
    always @(posedge ref_clk) begin
        if (cyc >= LIMIT) begin
            errors++;
            final_report();
        end
    end

    // =====================================================================
    // pin monitor, sampled at the falling edge where outputs are settled
    always @(negedge ref_clk) begin
        if (mon_on) begin
            cyc++;
            if (frame_clk && !fc_p) begin
                if (fr_c != 0) check(cyc - fr_c, 16);
                fr_c = cyc;
                rise_pend = 1;
            end
            if (!frame_clk && fc_p) begin
                check(cyc - fr_c, 4);
                if (ff_seen) check(sf_n, 4);
                ff_seen = 1;
                sf_n = 0;
            end
            if (!slave_clock_output && sc_p) begin
                if (sf_c != 0) check(cyc - sf_c, 4);
                if (rise_pend) check(cyc - fr_c, 1);
                sf_c = cyc;
                rise_pend = 0;
                sf_n++;
            end
            if (!slave_reset_n && st_p == 4'hF && channel_select_strobe == 4'h0) st_n++;
            if (slave_reset_n && !sr_p) check(st_n, 8);
            if (slave_reset_n && !sr_p) check(channel_select_strobe, 4'hF);
            run_n = slave_reset_n ? run_n + 1 : 0;
            // strobes follow the select level one clock later
            if (run_n > 2) check(channel_select_strobe, aux_sel);
            if (frame_bits_valid) begin
                fv_total++;
                fv_n++;
                if (fv_total > 3) check(frame_bits, exp_bits);
                nb = adcm_pkg::adcm_bits_s'(16'($urandom));
            end
            if (samples_valid) begin
                if (sv_seen) check(fv_n, DEC);
                sv_seen = 1;
                fv_n = 0;
            end
            fc_p = frame_clk;
            sc_p = slave_clock_output;
            sr_p = slave_reset_n;
            st_p = channel_select_strobe;
            aux_sel <= 4'($urandom);
        end
    end

    // =====================================================================
    // main sequence
    initial begin
        reset = 1'b1;
        aux_sel = 4'h0;
        present = 4'hF;
        nb = '0;
        // corner offsets: most negative, most positive, minus one, zero
        offs = {8'h00, 8'hFF, 8'h7F, 8'h80};
        void'($urandom(16));
        repeat (16) @(negedge ref_clk);
        check(slave_reset_n, 1'b0);
        check(channel_select_strobe, 4'hF);
        reset = 1'b0;
        mon_on = 1;
        for (int pass = 0; pass < 2; pass++) begin
            wait_frames(40);
            for (int ch = 0; ch < 4; ch++) begin
                check(temp_offset[ch], offs[ch]);
            end
            check(temp_valid, 4'hF);
            offs = 32'($urandom);
        end
        // slave 3 removed: its line stays high from here on
        present = 4'h7;
        // a word cut short by the removal can still close its delimiters, let it pass
        wait_frames(20);
        hold = temp_offset[3];
        wait_frames(800);
        check(temp_offset[3], hold);
        check(temp_valid, 4'hF);
        check(samples[3], 32'h0);
        // every slave removed: all samples settle to zero
        present = 4'h0;
        wait_frames(200);
        for (int ch = 0; ch < 4; ch++) begin
            check(samples[ch], 32'h0);
        end
        final_report();
    end
endmodule
